// File: src/ccsu_pkg.sv
// constants, types and reset settings for the common command status unit
package ccsu_pkg;
  typedef enum logic [3:0] {
    CMD_CLS = 4'h0, CMD_ESE = 4'h1, CMD_ESE_Q = 4'h2, CMD_ESR_Q = 4'h3,
    CMD_IDN_Q = 4'h4, CMD_OPC = 4'h5, CMD_OPC_Q = 4'h6, CMD_OPT_Q = 4'h7,
    CMD_PSC = 4'h8, CMD_PSC_Q = 4'h9, CMD_RCL = 4'hA, CMD_RST = 4'hB,
    CMD_SAV = 4'hC, CMD_SRE = 4'hD, CMD_SRE_Q = 4'hE, CMD_STB_Q = 4'hF
  } ccsu_cmd_t;
  typedef enum logic [2:0] {
    ST_POR = 3'h1, ST_IDLE = 3'h2, ST_OPCQ = 3'h4
  } ccsu_state_t;
  // event bit positions
  localparam int EVB_PON = 7;
  localparam int EVB_CME = 5;
  localparam int EVB_EXE = 4;
  localparam int EVB_DDE = 3;
  localparam int EVB_QUE = 2;
  localparam int EVB_OPC = 0;
  localparam logic [7:0] EV_MASK = 8'hBD;
  // status byte positions
  localparam int SBB_OPER = 7;
  localparam int SBB_MSS = 6;
  localparam int SBB_ESB = 5;
  localparam int SBB_MAV = 4;
  localparam int SBB_QUES = 3;
  localparam logic [7:0] SRE_MASK = 8'hBF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] LAST_LOC = 2'h3;
  localparam logic [7:0] OPT_NONE = 8'h00;
  localparam logic [7:0] OPC_ANSWER = 8'h01;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NL = 8'h0A;
  // identity string; maker and model values are arbitrary
  localparam int IDN_LEN = 23;
  localparam logic [8*IDN_LEN-1:0] IDN_STR = "VENDOR,00000A,0,A.00.00";
  typedef struct packed {
    logic        output_on;
    logic [15:0] volt_prog;
    logic [15:0] sweep_point_count;
    logic [15:0] sample_interval;   // in ns
    logic [15:0] protection_delay;  // in ms
    logic        acq_src_bus;
    logic        tran_src_bus;
    logic [1:0]  acq_slope_curr;    // 0 positive
    logic [1:0]  acq_slope_volt;
  } ccsu_settings_t;
  localparam real RST_SAMPLE_INTERVAL_US = 15.6;
  localparam real RST_PROTECTION_DELAY_S = 0.08;
  localparam ccsu_settings_t RST_SETTINGS = '{
    output_on: 1'b0, volt_prog: 16'h0000, sweep_point_count: 16'd2048,
    sample_interval: 16'(int'(RST_SAMPLE_INTERVAL_US * 1000.0)),
    protection_delay: 16'(int'(RST_PROTECTION_DELAY_S * 1000.0)),
    acq_src_bus: 1'b0, tran_src_bus: 1'b1,
    acq_slope_curr: 2'h0, acq_slope_volt: 2'h0};
endpackage

// File: src/ccsu_if.sv
// links between the command core, its answer streamer and its state store
`timescale 1ns/1ps
interface ccsu_resp_if;
  import ccsu_pkg::*;
  logic       start;
  logic       idn;
  logic [7:0] value;
  logic       flush;
  logic       busy;
  modport core (output start, idn, value, flush, input busy);
  modport gen  (input start, idn, value, flush, output busy);
endinterface

interface ccsu_store_if;
  import ccsu_pkg::*;
  logic [1:0]     rd_loc;
  ccsu_settings_t rd_data;
  logic           wr_en;
  logic [1:0]     wr_loc;
  ccsu_settings_t wr_data;
  logic           nv_wr;
  logic [7:0]     nv_ese_w, nv_sre_w, nv_ese, nv_sre;
  logic           nv_psc_w, nv_psc;
  modport core  (output rd_loc, wr_en, wr_loc, wr_data, nv_wr, nv_ese_w, nv_sre_w, nv_psc_w,
                 input rd_data, nv_ese, nv_sre, nv_psc);
  modport store (input rd_loc, wr_en, wr_loc, wr_data, nv_wr, nv_ese_w, nv_sre_w, nv_psc_w,
                 output rd_data, nv_ese, nv_sre, nv_psc);
endinterface

// File: src/ccsu_store.sv
// nonvolatile saved states and enable registers, kept across reset
`timescale 1ns/1ps
module ccsu_store
  import ccsu_pkg::*;
(
  input  wire logic   sys_clk_i,
  ccsu_store_if.store sif
);
  ccsu_settings_t mem [4] = '{default: RST_SETTINGS};
  logic [7:0]     ese_nv = REG_RESET;
  logic [7:0]     sre_nv = REG_RESET;
  logic           psc_nv = 1'b1;

  // storage has no reset on purpose: it models nonvolatile memory
  always_ff @(posedge sys_clk_i) begin
    if (sif.wr_en) begin
      mem[sif.wr_loc] <= sif.wr_data;
    end
    if (sif.nv_wr) begin
      ese_nv <= sif.nv_ese_w;
      sre_nv <= sif.nv_sre_w;
      psc_nv <= sif.nv_psc_w;
    end
  end

  assign sif.rd_data = mem[sif.rd_loc];
  assign sif.nv_ese  = ese_nv;
  assign sif.nv_sre  = sre_nv;
  assign sif.nv_psc  = psc_nv;
endmodule

// File: src/ccsu_resp_gen.sv
// output queue: streams decimal or identity answers as ASCII bytes
`timescale 1ns/1ps
module ccsu_resp_gen
  import ccsu_pkg::*;
(
  input  wire logic  sys_clk_i,
  input  wire logic  nrst_i,
  ccsu_resp_if.gen   rif,
  output logic       resp_valid_o,
  output logic [7:0] resp_data_o,
  input  wire logic  resp_ready_i
);
  logic [4:0] idx_q, idx_d, len_q, len_d;
  logic       idn_q, idn_d, act_q, act_d;
  logic [7:0] val_q, val_d, byte_q, byte_d;

  // character at position p of the answer, newline last
  function automatic logic [7:0] char_at(input logic idn, input logic [7:0] v,
                                         input logic [4:0] p);
    logic [1:0] nd;
    logic [7:0] dig;
    nd  = (v >= 8'd100) ? 2'd3 : ((v >= 8'd10) ? 2'd2 : 2'd1);
    dig = 8'h00;
    if (idn) begin
      char_at = (int'(p) < IDN_LEN) ? IDN_STR[8*(IDN_LEN-1-int'(p)) +: 8] : ASCII_NL;
    end else if (p >= 5'(nd)) begin
      char_at = ASCII_NL;
    end else begin
      case (nd - 2'(p))
        2'd3:    dig = v / 8'd100;
        2'd2:    dig = (v / 8'd10) % 8'd10;
        default: dig = v % 8'd10;
      endcase
      char_at = ASCII_ZERO + dig;
    end
  endfunction

  // next-state for the streamer
  always_comb begin
    idx_d = idx_q; len_d = len_q; idn_d = idn_q; val_d = val_q;
    act_d = act_q; byte_d = byte_q;
    if (rif.flush) begin
      act_d = 1'b0;
    end else if (rif.start) begin
      act_d  = 1'b1;
      idx_d  = 5'h00;
      idn_d  = rif.idn;
      val_d  = rif.value;
      len_d  = rif.idn ? 5'(IDN_LEN + 1) :
               ((rif.value >= 8'd100) ? 5'd4 : ((rif.value >= 8'd10) ? 5'd3 : 5'd2));
      byte_d = char_at(rif.idn, rif.value, 5'h00);
    end else if (act_q && resp_ready_i) begin
      if (idx_q + 5'd1 == len_q) begin
        act_d = 1'b0;
      end else begin
        idx_d  = idx_q + 5'd1;
        byte_d = char_at(idn_q, val_q, idx_q + 5'd1);
      end
    end
  end

  // streamer registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idx_q <= 5'h00; len_q <= 5'h00; idn_q <= 1'b0; val_q <= 8'h00;
      act_q <= 1'b0; byte_q <= 8'h00;
    end else begin
      idx_q <= idx_d; len_q <= len_d; idn_q <= idn_d; val_q <= val_d;
      act_q <= act_d; byte_q <= byte_d;
    end
  end

  assign resp_valid_o = act_q;
  assign resp_data_o  = byte_q;
  assign rif.busy     = act_q;
endmodule

// File: src/ccsu_top.sv
// common command interpreter with standard event status and status byte
`timescale 1ns/1ps
module ccsu_top
  import ccsu_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic            nrst_i,
  input  wire logic            cmd_valid_i,
  input  wire ccsu_cmd_t       cmd_code_i,
  input  wire logic [7:0]      cmd_param_i,
  input  wire logic            cmd_after_nl_i,
  input  wire logic            cmd_overlap_i,
  output logic                 cmd_ready_o,
  output logic                 cmd_ack_o,
  input  wire logic            cme_evt_i,
  input  wire logic            exe_evt_i,
  input  wire logic            dde_evt_i,
  input  wire logic            que_evt_i,
  input  wire logic            ovl_done_i,
  input  wire logic            trig_busy_i,
  input  wire logic            oper_sum_i,
  input  wire logic            ques_sum_i,
  input  wire logic            pon_state_sel_i,
  input  wire logic            set_wr_i,
  input  wire ccsu_settings_t  set_data_i,
  output ccsu_settings_t       settings_o,
  output logic                 trig_abort_o,
  output logic                 cal_disable_o,
  output logic                 status_clear_o,
  output logic                 err_queue_clear_o,
  output logic [7:0]           status_byte_o,
  output logic                 srq_o,
  output logic [7:0]           event_enable_o,
  output logic                 resp_valid_o,
  output logic [7:0]           resp_data_o,
  input  wire logic            resp_ready_i
);
  ccsu_resp_if  rif ();
  ccsu_store_if sif ();

  ccsu_state_t    state_q, state_d;
  logic [7:0]     ese_q, ese_d, sre_q, sre_d, flags_q, flags_d;
  logic           psc_q, psc_d;
  ccsu_settings_t set_q, set_d;
  logic [7:0]     ovl_cnt_q, ovl_cnt_d, opc_wait_q, opc_wait_d;
  logic           opc_arm_q, opc_arm_d;
  logic           abort_q, abort_d, cal_q, cal_d, stclr_q, stclr_d;
  logic           errclr_q, errclr_d;
  logic           take, is_query, pending, param_bad;
  logic [7:0]     ev_in, clr_mask, stb_raw;

  ccsu_resp_gen u_resp (
    .sys_clk_i    (sys_clk_i),
    .nrst_i       (nrst_i),
    .rif          (rif),
    .resp_valid_o (resp_valid_o),
    .resp_data_o  (resp_data_o),
    .resp_ready_i (resp_ready_i)
  );

  ccsu_store u_store (
    .sys_clk_i (sys_clk_i),
    .sif       (sif)
  );

  // queries need the output queue; other commands pass while it drains
  always_comb begin
    case (cmd_code_i)
      CMD_ESE_Q, CMD_ESR_Q, CMD_IDN_Q, CMD_OPC_Q, CMD_OPT_Q,
      CMD_PSC_Q, CMD_SRE_Q, CMD_STB_Q: is_query = 1'b1;
      default:                         is_query = 1'b0;
    endcase
  end

  // handshake and pending-work view
  assign cmd_ready_o = (state_q == ST_IDLE) && !(is_query && rif.busy);
  assign cmd_ack_o   = cmd_valid_i && cmd_ready_o;
  assign take        = cmd_ack_o;
  assign pending     = (ovl_cnt_q != 8'h00) || trig_busy_i;
  assign param_bad   = ((cmd_code_i == CMD_RCL || cmd_code_i == CMD_SAV) &&
                        cmd_param_i > 8'(LAST_LOC)) ||
                       (cmd_code_i == CMD_PSC && cmd_param_i > 8'h01);

  // incoming events from the rest of the instrument and from commands with a bad parameter
  always_comb begin
    ev_in          = 8'h00;
    ev_in[EVB_CME] = cme_evt_i;
    ev_in[EVB_EXE] = exe_evt_i || (take && param_bad);
    ev_in[EVB_DDE] = dde_evt_i;
    ev_in[EVB_QUE] = que_evt_i;
  end

  // status byte; summaries recomputed every cycle
  always_comb begin
    stb_raw           = 8'h00;
    stb_raw[SBB_OPER] = oper_sum_i;
    stb_raw[SBB_ESB]  = |(flags_q & ese_q);
    stb_raw[SBB_MAV]  = rif.busy;
    stb_raw[SBB_QUES] = ques_sum_i;
  end
  assign srq_o         = |(stb_raw & sre_q & SRE_MASK);
  assign status_byte_o = stb_raw | (8'(srq_o) << SBB_MSS);

  // command execution, power-on sequence and overlap tracking
  always_comb begin
    state_d = state_q; ese_d = ese_q; sre_d = sre_q; psc_d = psc_q;
    set_d = set_q; ovl_cnt_d = ovl_cnt_q; opc_wait_d = opc_wait_q;
    opc_arm_d = opc_arm_q; abort_d = 1'b0; cal_d = 1'b0;
    stclr_d = 1'b0; errclr_d = 1'b0; clr_mask = 8'hFF;
    rif.start = 1'b0; rif.idn = 1'b0; rif.value = 8'h00; rif.flush = 1'b0;
    sif.rd_loc = cmd_param_i[1:0]; sif.wr_en = 1'b0; sif.wr_loc = cmd_param_i[1:0];
    sif.wr_data = set_q; sif.nv_wr = 1'b0;
    sif.nv_ese_w = ese_q; sif.nv_sre_w = sre_q; sif.nv_psc_w = psc_q;
    // settings written by other subsystems
    if (set_wr_i) begin
      set_d = set_data_i;
    end
    // overlapped work counted until its done pulse
    if (take && cmd_overlap_i) begin
      ovl_cnt_d = ovl_cnt_d + 8'h01;
    end
    if (ovl_done_i && ovl_cnt_q != 8'h00) begin
      ovl_cnt_d = ovl_cnt_d - 8'h01;
    end
    if (ovl_done_i && opc_wait_q != 8'h00) begin
      opc_wait_d = opc_wait_q - 8'h01;
    end
    case (state_q)
      ST_POR: begin
        sif.rd_loc = 2'h0;
        psc_d      = sif.nv_psc;
        if (sif.nv_psc) begin
          ese_d = REG_RESET;
          sre_d = REG_RESET;
        end else begin
          ese_d = sif.nv_ese;
          sre_d = sif.nv_sre;
        end
        set_d   = pon_state_sel_i ? sif.rd_data : RST_SETTINGS;
        state_d = ST_IDLE;
      end
      ST_OPCQ: begin
        if (!pending) begin
          rif.start = 1'b1;
          rif.value = OPC_ANSWER;
          state_d   = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take && !param_bad) begin
          case (cmd_code_i)
            CMD_CLS: begin
              clr_mask  = 8'h00;
              stclr_d   = 1'b1;
              errclr_d  = 1'b1;
              opc_arm_d = 1'b0;
              rif.flush = cmd_after_nl_i;
            end
            CMD_ESE: begin
              ese_d        = cmd_param_i & EV_MASK;
              sif.nv_ese_w = cmd_param_i & EV_MASK;
              sif.nv_wr    = 1'b1;
            end
            CMD_SRE: begin
              sre_d        = cmd_param_i & SRE_MASK;
              sif.nv_sre_w = cmd_param_i & SRE_MASK;
              sif.nv_wr    = 1'b1;
            end
            CMD_PSC: begin
              psc_d        = cmd_param_i[0];
              sif.nv_psc_w = cmd_param_i[0];
              sif.nv_wr    = 1'b1;
            end
            CMD_ESE_Q: begin
              rif.start = 1'b1;
              rif.value = ese_q;
            end
            CMD_ESR_Q: begin
              rif.start = 1'b1;
              rif.value = flags_q;
              clr_mask  = 8'h00;
            end
            CMD_SRE_Q: begin
              rif.start = 1'b1;
              rif.value = sre_q;
            end
            CMD_PSC_Q: begin
              rif.start = 1'b1;
              rif.value = 8'(psc_q);
            end
            CMD_STB_Q: begin
              rif.start = 1'b1;
              rif.value = status_byte_o;
            end
            CMD_IDN_Q: begin
              rif.start = 1'b1;
              rif.idn   = 1'b1;
            end
            CMD_OPT_Q: begin
              rif.start = 1'b1;
              rif.value = OPT_NONE;
            end
            CMD_OPC: begin
              opc_arm_d  = 1'b1;
              opc_wait_d = ovl_cnt_d;
            end
            CMD_OPC_Q: begin
              state_d = ST_OPCQ;
            end
            CMD_RCL: begin
              set_d   = sif.rd_data;
              set_d.acq_src_bus = set_q.acq_src_bus;
              set_d.tran_src_bus = set_q.tran_src_bus;
              set_d.acq_slope_curr = set_q.acq_slope_curr;
              set_d.acq_slope_volt = set_q.acq_slope_volt;
              abort_d = 1'b1;
              cal_d   = 1'b1;
            end
            CMD_RST: begin
              set_d   = RST_SETTINGS;
              abort_d = 1'b1;
              cal_d   = 1'b1;
            end
            CMD_SAV: begin
              sif.wr_en = 1'b1;
            end
            default: begin
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // completion flag waits for earlier work and the trigger system
    flags_d = (flags_q & clr_mask) | ev_in;
    if (state_q == ST_POR) begin
      flags_d[EVB_PON] = 1'b1;
    end
    if (opc_arm_q && opc_wait_q == 8'h00 && !trig_busy_i) begin
      flags_d[EVB_OPC] = 1'b1;
      if (opc_arm_d == opc_arm_q && !(take && cmd_code_i == CMD_OPC)) begin
        opc_arm_d = 1'b0;
      end
    end
    flags_d = flags_d & EV_MASK;
  end

  // state registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_POR; ese_q <= REG_RESET; sre_q <= REG_RESET; psc_q <= 1'b1;
      flags_q <= REG_RESET; set_q <= RST_SETTINGS; ovl_cnt_q <= 8'h00;
      opc_wait_q <= 8'h00; opc_arm_q <= 1'b0; abort_q <= 1'b0; cal_q <= 1'b0;
      stclr_q <= 1'b0; errclr_q <= 1'b0;
    end else begin
      state_q <= state_d; ese_q <= ese_d; sre_q <= sre_d; psc_q <= psc_d;
      flags_q <= flags_d; set_q <= set_d; ovl_cnt_q <= ovl_cnt_d;
      opc_wait_q <= opc_wait_d; opc_arm_q <= opc_arm_d; abort_q <= abort_d;
      cal_q <= cal_d; stclr_q <= stclr_d; errclr_q <= errclr_d;
    end
  end

  // registered outputs
  assign settings_o        = set_q;
  assign trig_abort_o      = abort_q;
  assign cal_disable_o     = cal_q;
  assign status_clear_o    = stclr_q;
  assign err_queue_clear_o = errclr_q;
  assign event_enable_o    = ese_q;

  // checks on the behaviour above
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence opcq_taken;
    take && cmd_code_i == CMD_OPC_Q;
  endsequence
  sequence work_drained;
    (ovl_cnt_q == 8'h00) && !trig_busy_i;
  endsequence

  cls_clear_a: assert property (take && cmd_code_i == CMD_CLS && ev_in == 8'h00
    && !opc_arm_q |=> flags_q == 8'h00 && status_clear_o && err_queue_clear_o)
    else $error("clear-status left event flags set");
  cls_flush_a: assert property (take && cmd_code_i == CMD_CLS && cmd_after_nl_i
    |=> !resp_valid_o)
    else $error("output queue not flushed");
  ese_write_a: assert property (take && cmd_code_i == CMD_ESE
    |=> ese_q == ($past(cmd_param_i) & EV_MASK))
    else $error("event enable mask not stored");
  esb_sum_a: assert property (status_byte_o[SBB_ESB] == |(flags_q & ese_q))
    else $error("event summary bit wrong");
  rsvd_zero_a: assert property ((flags_q & ~EV_MASK) == 8'h00
    && (ese_q & ~EV_MASK) == 8'h00)
    else $error("reserved event bit set");
  esr_clear_a: assert property (take && cmd_code_i == CMD_ESR_Q && ev_in == 8'h00
    && !opc_arm_q |=> flags_q == 8'h00 ##1 resp_valid_o)
    else $error("event query did not clear");
  opc_hold_a: assert property (opc_arm_q && trig_busy_i && !flags_q[EVB_OPC]
    && !(take && cmd_code_i == CMD_CLS) |=> !flags_q[EVB_OPC])
    else $error("completion set while trigger busy");
  opc_flow_a: assert property (take && cmd_code_i == CMD_OPC |=> state_q == ST_IDLE)
    else $error("completion command stalled stream");
  opcq_block_a: assert property (state_q == ST_OPCQ && pending |-> !cmd_ready_o)
    else $error("commands taken during completion query");
  opcq_answer_a: assert property (opcq_taken ##1 work_drained
    |=> resp_valid_o && resp_data_o == ASCII_ZERO + OPC_ANSWER)
    else $error("completion query answer missing");
  pon_psc_a: assert property (state_q == ST_POR && sif.nv_psc
    |=> ese_q == REG_RESET && sre_q == REG_RESET && flags_q[EVB_PON])
    else $error("enables not cleared at power-on");
  rcl_abort_a: assert property (take && cmd_code_i == CMD_RCL && !param_bad
    |=> trig_abort_o && cal_disable_o)
    else $error("recall did not abort trigger");
  rst_load_a: assert property (take && cmd_code_i == CMD_RST && !set_wr_i
    |=> trig_abort_o && settings_o == RST_SETTINGS)
    else $error("reset settings not loaded");
  mss_sum_a: assert property (srq_o == status_byte_o[SBB_MSS]
    && srq_o == |(stb_raw & sre_q & SRE_MASK))
    else $error("master summary wrong");
endmodule

// File: verif/ccsu_host_model.sv
// remote host model: sinks answer bytes, prompt or every other cycle
`timescale 1ns/1ps
module ccsu_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       slow_i,
  input  wire logic       resp_valid_i,
  input  wire logic [7:0] resp_data_i,
  output logic            resp_ready_o
);
  logic [7:0] rx [$];
  logic       rdy_q = 1'b0;
  assign resp_ready_o = rdy_q;
  // take a byte at the edge where valid and ready meet, in stream order
  always @(posedge sys_clk_i) begin
    if (resp_valid_i && rdy_q) rx.push_back(resp_data_i);
    rdy_q <= slow_i ? ~rdy_q : 1'b1;
  end
endmodule

// File: verif/tb.sv
// self-checking bench for the common command status unit
`timescale 1ns/1ps
module tb;
  import ccsu_pkg::*;
  logic           sys_clk_i = 0, nrst_i = 0, cmd_valid_i = 0, cmd_after_nl_i = 0;
  logic           cmd_overlap_i = 0, cme_evt_i = 0, exe_evt_i = 0, dde_evt_i = 0;
  logic           que_evt_i = 0, ovl_done_i = 0, set_wr_i = 0, slow = 0, a;
  logic           trig_busy = 0, pon_sel = 0, stclr, errclr;
  ccsu_cmd_t      cmd_code_i = CMD_CLS;
  logic [7:0]     cmd_param_i = 8'h00;
  ccsu_settings_t set_data_i = RST_SETTINGS, settings_o;
  logic           cmd_ready_o, cmd_ack_o, trig_abort_o, cal_disable_o, srq_o;
  logic           resp_valid_o, resp_ready_i;
  logic [7:0]     status_byte_o, event_enable_o, resp_data_o;
  int             error_cnt = 0, samples_checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  ccsu_top ccsu_top_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_param_i(cmd_param_i), .cmd_after_nl_i(cmd_after_nl_i),
    .cmd_overlap_i(cmd_overlap_i), .cmd_ready_o(cmd_ready_o), .cmd_ack_o(cmd_ack_o),
    .cme_evt_i(cme_evt_i), .exe_evt_i(exe_evt_i), .dde_evt_i(dde_evt_i),
    .que_evt_i(que_evt_i), .ovl_done_i(ovl_done_i), .trig_busy_i(trig_busy),
    .oper_sum_i(1'b0), .ques_sum_i(1'b0), .pon_state_sel_i(pon_sel), .set_wr_i(set_wr_i),
    .set_data_i(set_data_i), .settings_o(settings_o), .trig_abort_o(trig_abort_o),
    .cal_disable_o(cal_disable_o), .status_clear_o(stclr), .err_queue_clear_o(errclr),
    .status_byte_o(status_byte_o), .srq_o(srq_o), .event_enable_o(event_enable_o),
    .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .resp_ready_i(resp_ready_i));
  ccsu_host_model ccsu_host_model_i (.sys_clk_i(sys_clk_i), .slow_i(slow),
    .resp_valid_i(resp_valid_o), .resp_data_i(resp_data_o), .resp_ready_o(resp_ready_i));
  // verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // strobe one command, hold it until acknowledged
  task automatic send(input ccsu_cmd_t c, input logic [7:0] p);
    int n;
    n = 0;
    cmd_code_i = c;
    cmd_param_i = p;
    cmd_valid_i = 1'b1;
    #1;
    while (cmd_ack_o !== 1'b1 && n < 50) begin
      tick(1);
      #1;
      n++;
    end
    if (n == 50) begin
      chk(1'b0, "command not acknowledged");
      conclude();
    end
    tick(1);
    cmd_valid_i = 1'b0;
    cmd_after_nl_i = 1'b0;
    cmd_overlap_i = 1'b0;
  endtask
  // wait for a newline-ended answer and compare it
  task automatic collect(input string s);
    int  n;
    logic ok;
    n = 0;
    while (n < 300 && !(ccsu_host_model_i.rx.size() > 0 && ccsu_host_model_i.rx[$] === 8'h0A))
    begin
      tick(1);
      n++;
    end
    if (n == 300) begin
      chk(1'b0, "answer never ended");
      conclude();
    end
    ok = (ccsu_host_model_i.rx.size() == s.len() + 1);
    for (int i = 0; ok && i < s.len(); i++) ok = (ccsu_host_model_i.rx[i] === 8'(s[i]));
    chk(ok, {"wrong answer, expected ", s});
  endtask
  task automatic query(input ccsu_cmd_t c, input string s);
    ccsu_host_model_i.rx.delete();
    send(c, 8'h00);
    collect(s);
  endtask
  // event register read, clear and bit layout
  task automatic t_events();
    query(CMD_ESR_Q, "128");
    query(CMD_ESR_Q, "0");
    {cme_evt_i, exe_evt_i, dde_evt_i, que_evt_i} = 4'hF;
    tick(1);
    {cme_evt_i, exe_evt_i, dde_evt_i, que_evt_i} = 4'h0;
    query(CMD_ESR_Q, "60");
    send(CMD_RCL, 8'h07);
    query(CMD_ESR_Q, "16");
  endtask
  // enable mask, summary bits and clear-status
  task automatic t_summary();
    slow = 1'b1;
    send(CMD_ESE, 8'h81);
    tick(1);
    chk(event_enable_o === 8'h81, "enable mask");
    query(CMD_ESE_Q, "129");
    slow = 1'b0;
    send(CMD_ESE, 8'h04);
    que_evt_i = 1'b1;
    tick(1);
    que_evt_i = 1'b0;
    tick(1);
    chk(status_byte_o[SBB_ESB] === 1'b1, "summary bit");
    send(CMD_SRE, 8'h20);
    tick(1);
    chk(srq_o === 1'b1 && status_byte_o[SBB_MSS] === 1'b1, "master summary");
    send(CMD_IDN_Q, 8'h00);
    cmd_after_nl_i = 1'b1;
    send(CMD_CLS, 8'h00);
    chk(stclr === 1'b1 && errclr === 1'b1, "clear pulses");
    chk(status_byte_o === 8'h00 && resp_valid_o === 1'b0, "status after clear");
  endtask
  // factory reset, recall and completion signalling
  task automatic t_reset_opc();
    set_data_i = ~RST_SETTINGS;
    set_wr_i = 1'b1;
    tick(1);
    set_wr_i = 1'b0;
    cmd_overlap_i = 1'b1;
    send(CMD_RST, 8'h00);
    tick(1);
    chk(settings_o === RST_SETTINGS, "factory settings");
    send(CMD_OPC, 8'h00);
    query(CMD_ESE_Q, "4");
    query(CMD_ESR_Q, "0");
    ovl_done_i = 1'b1;
    tick(1);
    ovl_done_i = 1'b0;
    tick(3);
    query(CMD_ESR_Q, "1");
    trig_busy = 1'b1;
    send(CMD_OPC, 8'h00);
    tick(3);
    query(CMD_ESR_Q, "0");
    trig_busy = 1'b0;
    tick(3);
    query(CMD_ESR_Q, "1");
    send(CMD_RCL, 8'h00);
    a = trig_abort_o & cal_disable_o;
    tick(1);
    a = a | (trig_abort_o & cal_disable_o);
    chk(a === 1'b1, "recall abort");
    cmd_overlap_i = 1'b1;
    send(CMD_RST, 8'h00);
    ccsu_host_model_i.rx.delete();
    send(CMD_OPC_Q, 8'h00);
    tick(6);
    chk(ccsu_host_model_i.rx.size() == 0 && cmd_ready_o === 1'b0, "early answer");
    ovl_done_i = 1'b1;
    tick(1);
    ovl_done_i = 1'b0;
    collect("1");
  endtask
  // kept enables, saved state and power-on recall across a second reset
  task automatic t_power();
    send(CMD_PSC, 8'h00);
    send(CMD_ESE, 8'h80);
    send(CMD_SRE, 8'h24);
    query(CMD_SRE_Q, "36");
    set_data_i = ~RST_SETTINGS;
    set_wr_i = 1'b1;
    tick(1);
    set_wr_i = 1'b0;
    send(CMD_SAV, 8'h00);
    send(CMD_RST, 8'h00);
    send(CMD_RCL, 8'h00);
    a = (settings_o.volt_prog === ~RST_SETTINGS.volt_prog);
    chk(a && settings_o.tran_src_bus === RST_SETTINGS.tran_src_bus, "recall");
    pon_sel = 1'b1;
    nrst_i = 1'b0;
    tick(2);
    nrst_i = 1'b1;
    tick(2);
    chk(event_enable_o === 8'h80 && srq_o === 1'b1, "enables kept");
    chk(settings_o === ~RST_SETTINGS, "power-on recall");
    query(CMD_STB_Q, "96");
    query(CMD_PSC_Q, "0");
    query(CMD_ESR_Q, "128");
  endtask
  // main sequence
  initial begin
    tick(12);
    nrst_i = 1'b1;
    tick(3);
    chk(event_enable_o === 8'h00, "enable at power-on");
    t_events();
    t_summary();
    t_reset_opc();
    t_power();
    query(CMD_IDN_Q, string'(IDN_STR));
    query(CMD_OPT_Q, "0");
    conclude();
  end
endmodule
